// ---- core/sts_cfg.svh ----
// offsets, bit positions and reset values of the status flag block
// assumes inclusion by bare name from core/ files
`ifndef STS_CFG_SVH
`define STS_CFG_SVH
// register byte offsets
`define STS_OFF_STATUS   8'h08
`define STS_OFF_OBUF     8'h10
`define STS_OFF_IBUF     8'h14
`define STS_OFF_WIN0     8'h20
`define STS_OFF_WLAST    8'h34
`define STS_OFF_WEN      8'h38
// status bit positions
`define STS_B_RXOVF      28
`define STS_B_RXUDF      27
`define STS_B_TXOVF      26
`define STS_B_TXUDF      25
`define STS_B_SIZE       24
`define STS_B_BUSY       23
`define STS_B_UNDEF      22
`define STS_B_BUSERR     21
`define STS_B_LIM0       20
`define STS_B_LIM1       19
`define STS_B_TXRST      18
`define STS_B_RXRST      17
`define STS_B_CFGRST     16
`define STS_B_OBF        15
`define STS_B_IBF        14
`define STS_B_TXFULL     11
// reset values, masks and axi response codes
`define STS_STATUS_RST   32'h0000_0000
`define STS_W1C_MASK     32'h1FFF_0000
`define STS_WORD_RST     32'h0000_0000
`define STS_RESP_OKAY    2'h0
`define STS_RESP_SLVERR  2'h2
`endif

// ---- core/sts_pkg.sv ----
// types shared by the status flag block
// assumes sts_cfg.svh supplies all numeric constants
package sts_pkg;
	// fifo request strobes from the internal datapath
	typedef struct packed {
		logic rx_wr;
		logic rx_rd;
		logic tx_wr;
		logic tx_rd;
	} sts_fifo_req_t;
	// fifo fill levels
	typedef struct packed {
		logic rx_full;
		logic rx_empty;
		logic tx_full;
		logic tx_empty;
	} sts_fifo_lvl_t;
	// one address window
	typedef struct packed {
		logic [31:0] base;
		logic [31:0] wlim;
		logic [31:0] rlim;
	} sts_win_t;
	// link frame tracking, gray along idle-active-end
	typedef enum logic [1:0] {
		STS_FR_IDLE   = 2'h0,
		STS_FR_ACTIVE = 2'h1,
		STS_FR_END    = 2'h3
	} sts_frame_t;
endpackage : sts_pkg

// ---- core/sts_status.sv ----
// status and error flag block of an spi target, firmware view over axi4-lite
// assumes datapath strobes are on aclk; sclk, cs_n and enables are async
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "sts_cfg.svh"
module sts_status #(
	parameter logic [255:0] CMD_KNOWN = 256'h0000_0000_0000_0000_0000_0000_0000_FFFF
) (
	// clock and reset
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	// axi4-lite write
	input  wire logic [7:0]            s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	// axi4-lite read
	input  wire logic [7:0]            s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	// spi link pins
	input  wire logic                  spi_sclk,
	input  wire logic                  spi_cs_n,
	// command decoder
	input  wire logic                  cmd_valid,
	input  wire logic [7:0]            cmd_code,
	input  wire logic [15:0]           cmd_bits,
	input  wire logic                  destination_busy_in,
	output logic                       cmd_accept,
	output logic                       size_shutdown,
	// fifo datapath
	input  wire sts_pkg::sts_fifo_req_t fifo_req,
	input  wire sts_pkg::sts_fifo_lvl_t fifo_lvl,
	output sts_pkg::sts_fifo_req_t      fifo_en,
	input  wire logic [31:0]           tx_rd_din,
	output logic [31:0]                tx_rd_dout,
	input  wire logic                  tx_fifo_rst_req,
	input  wire logic                  rx_fifo_rst_req,
	// internal bus and address check
	input  wire logic                  ahb_active,
	input  wire logic                  ahb_hready,
	input  wire logic                  ahb_hresp,
	input  wire logic                  req_addr_valid,
	input  wire logic                  req_is_write,
	input  wire logic [31:0]           req_addr,
	output logic                       addr_ok,
	// configuration reset and buffers
	input  wire logic                  cfg_rst_req,
	input  wire logic                  host_ibuf_wr,
	input  wire logic [31:0]           host_ibuf_data,
	input  wire logic                  obuf_master_read,
	output logic [31:0]                obuf_data,
	// master side interrupt
	input  wire logic [31:0]           master_int_en,
	output logic                       master_side_interrupt_line
);
	import sts_pkg::*;

	// window range check: out of range or window disabled
	function automatic logic win_bad(input sts_win_t w, input logic en,
		input logic wr, input logic [31:0] a);
		logic [31:0] top;
		top = w.base + (wr ? w.wlim : w.rlim);
		win_bad = !en || (a < w.base) || (a > top);
	endfunction : win_bad

	// word select of an axi address
	function automatic logic [7:0] word_of(input logic [7:0] a);
		word_of = {a[7:2], 2'h0};
	endfunction : word_of

	// synchronised link pins and enables
	logic [33:0] sync_o;
	logic        sclk_s, csn_s, sclk_p_q, csn_p_q;
	logic [31:0] int_en_s;
	sts_sync #(.W(34)) u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.din     ({spi_sclk, ~spi_cs_n, master_int_en}),
		.dout    (sync_o)
	);
	assign sclk_s   = sync_o[33];
	assign csn_s    = ~sync_o[32];  // carried inverted: flop reset reads as idle high
	assign int_en_s = sync_o[31:0];
	wire sclk_rise = sclk_s && !sclk_p_q;  // link clock edge
	wire csn_fall  = !csn_s && csn_p_q;    // frame start
	wire csn_rise  = csn_s && !csn_p_q;    // frame end

	// registers
	logic [31:0] status_q;               // sticky flags 28..16
	logic        obf_q, ibf_q;           // buffer flags
	logic [31:0] obuf_q, ibuf_q;         // buffer words
	sts_win_t    win_q [2];              // address windows
	logic [1:0]  wen_q;                  // window enables
	logic        txrst_pend_q, rxrst_pend_q;
	logic [15:0] bit_cnt_q, decl_q;      // clocked vs declared bits
	sts_frame_t  fr_q;
	logic        shut_q;
	logic [31:0] txlast_q;

	// axi write and read channel state
	logic        aw_hold_q, w_hold_q, bvalid_q;
	logic [7:0]  awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic [1:0]  bresp_q;
	logic        rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0]  rresp_q;

	// write decode
	wire        wr_fire  = aw_hold_q && w_hold_q && !bvalid_q;
	wire [7:0]  wa       = word_of(awaddr_q);
	wire        wr_stat  = wr_fire && (wa == `STS_OFF_STATUS);
	wire        wr_obuf  = wr_fire && (wa == `STS_OFF_OBUF);
	wire        wr_wen   = wr_fire && (wa == `STS_OFF_WEN);
	wire        wr_win   = wr_fire && (wa >= `STS_OFF_WIN0) && (wa <= `STS_OFF_WLAST);
	wire        wr_ok    = wr_stat || wr_obuf || wr_wen || wr_win
		|| (wa == `STS_OFF_IBUF);
	wire [31:0] strb_m   = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}},
		{8{wstrb_q[0]}}};
	wire [31:0] wmerge   = wdata_q & strb_m;
	wire [2:0]  win_idx  = 3'((wa - `STS_OFF_WIN0) >> 2);

	// read decode
	wire        rd_fire  = s_axi_arvalid && s_axi_arready;
	wire [7:0]  ra       = word_of(s_axi_araddr);
	wire        rd_ibuf  = rd_fire && (ra == `STS_OFF_IBUF);

	// event detection
	wire ev_rxovf  = fifo_req.rx_wr && fifo_lvl.rx_full;
	wire ev_rxudf  = fifo_req.rx_rd && fifo_lvl.rx_empty;
	wire ev_txovf  = fifo_req.tx_wr && fifo_lvl.tx_full;
	wire ev_txudf  = fifo_req.tx_rd && fifo_lvl.tx_empty;
	wire ev_size   = (fr_q == STS_FR_END) && (bit_cnt_q < decl_q);
	wire cmd_known = CMD_KNOWN[cmd_code];
	wire ev_busy   = cmd_valid && cmd_known && destination_busy_in;
	wire ev_undef  = cmd_valid && !cmd_known;
	wire ev_buserr = ahb_active && ahb_hready && ahb_hresp;
	wire ev_lim0   = req_addr_valid && win_bad(win_q[0], wen_q[0], req_is_write,
		req_addr);
	wire ev_lim1   = req_addr_valid && win_bad(win_q[1], wen_q[1], req_is_write,
		req_addr);
	wire ev_txrst  = txrst_pend_q && fifo_lvl.tx_empty;
	wire ev_rxrst  = rxrst_pend_q && fifo_lvl.rx_empty;

	// set vector and write-one-clear vector
	logic [31:0] set_v;
	always_comb begin
		set_v = '0;
		set_v[`STS_B_RXOVF]  = ev_rxovf;
		set_v[`STS_B_RXUDF]  = ev_rxudf;
		set_v[`STS_B_TXOVF]  = ev_txovf;
		set_v[`STS_B_TXUDF]  = ev_txudf;
		set_v[`STS_B_SIZE]   = ev_size;
		set_v[`STS_B_BUSY]   = ev_busy;
		set_v[`STS_B_UNDEF]  = ev_undef;
		set_v[`STS_B_BUSERR] = ev_buserr;
		set_v[`STS_B_LIM0]   = ev_lim0;
		set_v[`STS_B_LIM1]   = ev_lim1;
		set_v[`STS_B_TXRST]  = ev_txrst;
		set_v[`STS_B_RXRST]  = ev_rxrst;
		set_v[`STS_B_CFGRST] = cfg_rst_req;
	end
	wire [31:0] clr_v    = wr_stat ? (wmerge & `STS_W1C_MASK) : 32'h0;
	wire [31:0] status_d = ((status_q & ~clr_v) | set_v) & `STS_W1C_MASK;

	// composed status word with read-only levels
	logic [31:0] status_rd;
	always_comb begin
		status_rd = status_q;
		status_rd[`STS_B_OBF]    = obf_q;
		status_rd[`STS_B_IBF]    = ibf_q;
		status_rd[`STS_B_TXFULL] = fifo_lvl.tx_full;
	end

	// datapath handshakes: refused strobes never reach the fifo
	assign fifo_en.rx_wr = fifo_req.rx_wr && !fifo_lvl.rx_full;
	assign fifo_en.rx_rd = fifo_req.rx_rd && !fifo_lvl.rx_empty;
	assign fifo_en.tx_wr = fifo_req.tx_wr && !fifo_lvl.tx_full;
	assign fifo_en.tx_rd = fifo_req.tx_rd && !fifo_lvl.tx_empty;
	assign cmd_accept    = cmd_valid && cmd_known && !destination_busy_in;
	assign addr_ok       = req_addr_valid && !ev_lim0 && !ev_lim1;
	assign tx_rd_dout    = txlast_q;
	assign size_shutdown = shut_q;
	assign obuf_data     = obuf_q;
	assign master_side_interrupt_line = |(status_rd & int_en_s);

	// sticky flags, set wins over clear
	always_ff @(posedge aclk) begin
		if (!aresetn) status_q <= `STS_STATUS_RST;
		else          status_q <= status_d;
	end

	// buffer flags: set wins over the clearing read
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			obf_q <= 1'b0;
			ibf_q <= 1'b0;
		end else begin
			obf_q <= wr_obuf || (obf_q && !obuf_master_read);
			ibf_q <= host_ibuf_wr || (ibf_q && !rd_ibuf);
		end
	end

	// buffer words and last tx word for underflow replay
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			obuf_q   <= `STS_WORD_RST;
			ibuf_q   <= `STS_WORD_RST;
			txlast_q <= `STS_WORD_RST;
		end else begin
			if (wr_obuf)       obuf_q   <= wmerge;
			if (host_ibuf_wr)  ibuf_q   <= host_ibuf_data;
			if (fifo_en.tx_rd) txlast_q <= tx_rd_din;
		end
	end

	// window registers, one generate slice per window
	for (genvar g = 0; g < 2; g++) begin : g_win
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				win_q[g] <= '0;
			end else if (wr_win && (win_idx == 3'(3*g))) begin
				win_q[g].base <= wmerge;
			end else if (wr_win && (win_idx == 3'(3*g+1))) begin
				win_q[g].wlim <= wmerge;
			end else if (wr_win && (win_idx == 3'(3*g+2))) begin
				win_q[g].rlim <= wmerge;
			end
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn)    wen_q <= 2'h0;
		else if (wr_wen) wen_q <= wmerge[1:0];
	end

	// fifo reset pending until the fifo reads empty
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			txrst_pend_q <= 1'b0;
			rxrst_pend_q <= 1'b0;
		end else begin
			txrst_pend_q <= tx_fifo_rst_req || (txrst_pend_q && !fifo_lvl.tx_empty);
			rxrst_pend_q <= rx_fifo_rst_req || (rxrst_pend_q && !fifo_lvl.rx_empty);
		end
	end

	// link edges and frame tracking
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sclk_p_q <= 1'b0;
			csn_p_q  <= 1'b1;
			fr_q     <= STS_FR_IDLE;
		end else begin
			sclk_p_q <= sclk_s;
			csn_p_q  <= csn_s;
			unique case (fr_q)
				STS_FR_IDLE:   if (csn_fall) fr_q <= STS_FR_ACTIVE;
				STS_FR_ACTIVE: if (csn_rise) fr_q <= STS_FR_END;
				STS_FR_END:    fr_q <= STS_FR_IDLE;
				default:       fr_q <= STS_FR_IDLE;
			endcase
		end
	end

	// bit count saturates at the declared size, excess is ignored
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bit_cnt_q <= 16'h0;
			decl_q    <= 16'h0;
			shut_q    <= 1'b0;
		end else begin
			if (csn_fall) bit_cnt_q <= 16'h0;
			else if (fr_q == STS_FR_ACTIVE && sclk_rise && bit_cnt_q < decl_q)
				bit_cnt_q <= bit_cnt_q + 16'h1;
			if (cmd_accept) decl_q <= cmd_bits;
			else if (fr_q == STS_FR_END) decl_q <= 16'h0;
			shut_q <= ev_size;
		end
	end

	// axi write: address and data taken in either order
	assign s_axi_awready = !aw_hold_q && !bvalid_q;
	assign s_axi_wready  = !w_hold_q && !bvalid_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_q <= 1'b0;
			w_hold_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			awaddr_q  <= 8'h0;
			wdata_q   <= 32'h0;
			wstrb_q   <= 4'h0;
			bresp_q   <= `STS_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_hold_q <= 1'b0;
				w_hold_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= wr_ok ? `STS_RESP_OKAY : `STS_RESP_SLVERR;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// axi read: one outstanding, data registered
	logic [31:0] rd_mux;
	logic        rd_hit;
	always_comb begin
		rd_hit = 1'b1;
		unique case (ra)
			`STS_OFF_STATUS: rd_mux = status_rd;
			`STS_OFF_OBUF:   rd_mux = obuf_q;
			`STS_OFF_IBUF:   rd_mux = ibuf_q;
			`STS_OFF_WEN:    rd_mux = {30'h0, wen_q};
			8'h20:           rd_mux = win_q[0].base;
			8'h24:           rd_mux = win_q[0].wlim;
			8'h28:           rd_mux = win_q[0].rlim;
			8'h2C:           rd_mux = win_q[1].base;
			8'h30:           rd_mux = win_q[1].wlim;
			`STS_OFF_WLAST:  rd_mux = win_q[1].rlim;
			default: begin
				rd_mux = 32'h0;
				rd_hit = 1'b0;
			end
		endcase
	end
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0;
			rresp_q  <= `STS_RESP_OKAY;
		end else if (rd_fire) begin
			rvalid_q <= 1'b1;
			rdata_q  <= rd_mux;
			rresp_q  <= rd_hit ? `STS_RESP_OKAY : `STS_RESP_SLVERR;
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// checks on driven behaviour
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	rx_drop_a: assert property (ev_rxovf |-> !fifo_en.rx_wr ##1 status_q[28])
		else $error("rx overflow not dropped or flagged");
	rx_udf_a: assert property (ev_rxudf |=> status_q[27])
		else $error("rx underflow not flagged");
	tx_replay_a: assert property (ev_txudf |=> status_q[25] && $stable(txlast_q))
		else $error("tx underflow did not replay last word");
	size_shut_a: assert property (ev_size |=> shut_q && status_q[24])
		else $error("short command without shutdown");
	busy_drop_a: assert property (ev_busy |-> !cmd_accept ##1 status_q[23])
		else $error("busy request not ignored");
	set_wins_a: assert property (wr_stat && set_v[22] |=> status_q[22])
		else $error("flag set lost to clear");
	w1c_clear_a: assert property (wr_stat && clr_v[21] && !set_v[21] |=> !status_q[21])
		else $error("write one did not clear");
	int_line_a: assert property (set_v[22] && int_en_s[22] |=>
		master_side_interrupt_line || !int_en_s[22])
		else $error("enabled flag did not raise interrupt");
	resp_one_a: assert property (wr_fire |=> s_axi_bvalid [*1] ##0 !s_axi_awready)
		else $error("write response not raised");
endmodule : sts_status

// ---- core/sts_sync.sv ----
// two-flop level synchroniser, parameterised width
// assumes inputs are levels from another clock domain or pins
`timescale 1ns/1ps
module sts_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         aclk,
	input  wire logic         aresetn,
	// asynchronous level in, synchronised level out
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta_q; // first stage, read only by second
	// two stages, reset to zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_q <= '0;
			dout   <= '0;
		end else begin
			meta_q <= din;
			dout   <= meta_q;
		end
	end
endmodule : sts_sync

// ---- testbench/sts_spi_master_model.sv ----
// behavioural spi master driving the link pins of the status block
// assumes the target samples sclk and cs_n on its own clock
`timescale 1ns/1ps
module sts_spi_master_model (
	// link pins toward the target
	output logic spi_sclk,
	output logic spi_cs_n
);
	// clock stands low and frame idle outside frames
	initial begin
		spi_sclk = 1'b0;
		spi_cs_n = 1'b1;
	end
	// one frame of n clock pulses, 200 ns period, offset off the bench grid
	task automatic frame(input int n);
		#3;
		spi_cs_n = 1'b0;
		#100;
		repeat (n) begin
			spi_sclk = 1'b1;
			#100;
			spi_sclk = 1'b0;
			#100;
		end
		spi_cs_n = 1'b1;
		#100;
	endtask : frame
endmodule : sts_spi_master_model

// ---- testbench/sts_status_tb.sv ----
// self-checking bench of the status flag block
// assumes the firmware side speaks axi4-lite and a model drives the link
`timescale 1ns/1ps
`include "sts_cfg.svh"
module sts_status_tb;
	import sts_pkg::*;
	// clock, reset, counters
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	int   seed = 32'hB4D5D452;
	int   n_errors = 0, cmp_count = 0, cyc = 0, n_sd = 0, i, k;
	// bus side
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, w, b, hd, rd;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, rr;
	// datapath side
	logic cmd_valid = 0, busy = 0, ahb_a = 0, ahb_r = 0, ahb_e = 0;
	logic [7:0] cmd_code = 8'h00;
	logic [15:0] cmd_bits = 16'h0;
	logic cmd_accept, size_shutdown, addr_ok, int_line;
	sts_fifo_req_t fifo_req = '0, fifo_en;
	sts_fifo_lvl_t fifo_lvl = '0;
	logic [31:0] tx_din = 32'h0, tx_dout, req_addr = 32'h0, ibuf_d = 32'h0, obuf_data;
	logic [31:0] int_en = 32'h0;
	logic txr = 0, rxr = 0, rav = 0, riw = 0, cfg = 0, ibw = 0, obr = 0;
	logic sclk, cs_n;
	// 40 MHz clock
	always #12.5 aclk = ~aclk;
	// partner on the link
	sts_spi_master_model u_m (.spi_sclk(sclk), .spi_cs_n(cs_n));
	sts_status u_dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .spi_sclk(sclk), .spi_cs_n(cs_n),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_bits(cmd_bits),
		.destination_busy_in(busy), .cmd_accept(cmd_accept), .size_shutdown(size_shutdown),
		.fifo_req(fifo_req), .fifo_lvl(fifo_lvl), .fifo_en(fifo_en), .tx_rd_din(tx_din),
		.tx_rd_dout(tx_dout), .tx_fifo_rst_req(txr), .rx_fifo_rst_req(rxr),
		.ahb_active(ahb_a), .ahb_hready(ahb_r), .ahb_hresp(ahb_e), .req_addr_valid(rav),
		.req_is_write(riw), .req_addr(req_addr), .addr_ok(addr_ok), .cfg_rst_req(cfg),
		.host_ibuf_wr(ibw), .host_ibuf_data(ibuf_d), .obuf_master_read(obr),
		.obuf_data(obuf_data), .master_int_en(int_en), .master_side_interrupt_line(int_line));
	// verdict and end of run
	task end_of_test;
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : end_of_test
	// value compare
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk
	// one axi write, response returned
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ta, tw, tb;
		@(posedge aclk);
		awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		// waits for the answer; only the hang guard ends a stall
		forever begin
			@(negedge aclk);
			ta = awvalid && awready; tw = wvalid && wready; tb = bvalid && bready;
			if (tb) r = bresp;
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tb) begin
				bready <= 1'b0;
				break;
			end
		end
	endtask : axi_wr
	// one axi read
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ta, tr;
		@(posedge aclk);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		// waits for the answer; only the hang guard ends a stall
		forever begin
			@(negedge aclk);
			ta = arvalid && arready; tr = rvalid && rready;
			if (tr) begin
				d = rdata; r = rresp;
			end
			@(posedge aclk);
			if (ta) arvalid <= 1'b0;
			if (tr) begin
				rready <= 1'b0;
				break;
			end
		end
	endtask : axi_rd
	// status read against expectation
	task automatic st_chk(input logic [31:0] e);
		axi_rd(`STS_OFF_STATUS, rd, rr);
		chk(rd, e, "status");
	endtask : st_chk
	// expected status of each datapath event
	function automatic logic [31:0] exp_of(input int k);
		case (k)
			0: return 32'h0040_0000;
			1: return 32'h0080_0000;
			2: return 32'h0020_0000;
			3: return 32'h0018_0000;
			4: return 32'h0004_0000;
			5: return 32'h0002_0000;
			6: return 32'h0001_0000;
			default: return 32'h0000_4000;
		endcase
	endfunction : exp_of
	// expected limit flags of each window probe
	function automatic logic [31:0] exp_win(input int p);
		case (p)
			0: return 32'h0008_0000;
			1: return 32'h0000_0000;
			2: return 32'h0010_0000;
			default: return 32'h0018_0000;
		endcase
	endfunction : exp_win
	// one datapath event strobe
	task automatic fire(input int k);
		@(posedge aclk);
		case (k)
			0: begin cmd_code <= 8'hF0; cmd_valid <= 1'b1; end
			1: begin cmd_code <= 8'h01; busy <= 1'b1; cmd_valid <= 1'b1; end
			2: begin ahb_a <= 1'b1; ahb_r <= 1'b1; ahb_e <= 1'b1; end
			3: rav <= 1'b1;
			4: txr <= 1'b1;
			5: rxr <= 1'b1;
			6: cfg <= 1'b1;
			default: begin ibw <= 1'b1; ibuf_d <= hd; end
		endcase
		@(negedge aclk);
		if (k < 2) chk(cmd_accept, 0, "cmd refused");
		@(posedge aclk);
		cmd_valid <= 0; busy <= 0; ahb_a <= 0; ahb_r <= 0; ahb_e <= 0;
		rav <= 0; txr <= 0; rxr <= 0; cfg <= 0; ibw <= 0;
	endtask : fire
	// hang guard and shutdown pulse counter, off the edge so the pulse has settled
	always @(negedge aclk) begin
		cyc++;
		if (size_shutdown === 1'b1) n_sd++;
		if (cyc == 20000) begin
			n_errors++;
			end_of_test;
		end
	end
	// main sequence
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		st_chk(32'h0);
		axi_wr(8'hF0, 32'hFFFF_FFFF, rr);
		chk(rr, `STS_RESP_SLVERR, "unmapped write");
		axi_rd(8'hF0, rd, rr);
		chk({rd[29:0], rr}, `STS_RESP_SLVERR, "unmapped read");
		w = $random(seed);
		@(posedge aclk);
		fifo_req <= 4'h1; tx_din <= w;
		@(negedge aclk);
		chk(32'(fifo_en), 1, "tx grant");
		@(posedge aclk);
		fifo_req <= '0; fifo_lvl <= 4'hF;
		for (i = 0; i < 4; i++) begin
			@(posedge aclk);
			fifo_req <= 4'h8 >> i; tx_din <= ~w;
			@(negedge aclk);
			chk(32'(fifo_en), 0, "fifo gate");
			@(posedge aclk);
			fifo_req <= '0;
			st_chk((32'h1 << (28 - i)) | 32'h800);
			axi_wr(`STS_OFF_STATUS, `STS_W1C_MASK, rr);
			st_chk(32'h800);
		end
		chk(tx_dout, w, "tx repeat");
		fifo_lvl <= 4'h5;
		// the bench checks each event's flag and interrupt, then clears it before going on
		for (k = 0; k < 8; k++) begin
			hd = $random(seed);
			@(posedge aclk);
			int_en <= exp_of(k);
			fire(k);
			st_chk(exp_of(k));
			@(negedge aclk);
			chk(int_line, 1, "int set");
			if (k == 7) begin
				axi_rd(`STS_OFF_IBUF, rd, rr);
				chk(rd, hd, "ibuf data");
			end else axi_wr(`STS_OFF_STATUS, `STS_W1C_MASK, rr);
			st_chk(32'h0);
			@(negedge aclk);
			chk(int_line, 0, "int clear");
		end
		// flag event lands in the same cycle as its clearing write
		fork
			axi_wr(`STS_OFF_STATUS, `STS_W1C_MASK, rr);
			begin
				repeat (2) @(posedge aclk);
				cmd_code <= 8'hF0; cmd_valid <= 1'b1;
				@(posedge aclk);
				cmd_valid <= 1'b0;
			end
		join
		st_chk(32'h0040_0000);
		axi_wr(`STS_OFF_STATUS, `STS_W1C_MASK, rr);
		b = $random(seed) & 32'h0FFF_FFF0;
		axi_wr(`STS_OFF_WIN0, b, rr);
		axi_wr(8'h24, 32'h100, rr);
		axi_wr(8'h2C, b + 32'h80, rr);
		axi_wr(8'h30, 32'h100, rr);
		axi_wr(`STS_OFF_WEN, 32'h3, rr);
		// probes: win0 only, both, win1 only, read past both read limits
		for (i = 0; i < 4; i++) begin
			@(posedge aclk);
			rav <= 1'b1; riw <= (i != 3);
			req_addr <= b + ((i == 0) ? 32'h10 : (i == 2) ? 32'h140 : 32'h90);
			@(negedge aclk);
			chk(addr_ok, (i == 1), "addr window");
			@(posedge aclk);
			rav <= 1'b0;
			st_chk(exp_win(i));
			axi_wr(`STS_OFF_STATUS, `STS_W1C_MASK, rr);
		end
		w = $random(seed);
		axi_wr(`STS_OFF_OBUF, w, rr);
		st_chk(32'h8000);
		chk(obuf_data, w, "obuf data");
		@(posedge aclk);
		obr <= 1'b1;
		@(posedge aclk);
		obr <= 1'b0;
		st_chk(32'h0);
		for (i = 0; i < 2; i++) begin
			@(posedge aclk);
			cmd_code <= 8'h02; cmd_bits <= 16'd8; cmd_valid <= 1'b1;
			@(negedge aclk);
			chk(cmd_accept, 1, "cmd taken");
			@(posedge aclk);
			cmd_valid <= 1'b0;
			u_m.frame(i ? 12 : 4);
			repeat (10) @(posedge aclk);
			st_chk(i ? 32'h0 : 32'h0100_0000);
			chk(32'(n_sd), 1, "shutdown pulses");
			axi_wr(`STS_OFF_STATUS, `STS_W1C_MASK, rr);
		end
		end_of_test;
	end
endmodule : sts_status_tb
